// [inc/ibt_pkg.sv]
// Shared constants for the I2C bus busy tracker
package ibt_pkg;
  localparam int SYNC_STAGES = 2;
  localparam logic BUSY_RESET = 1'h0;
  localparam logic BUSY_SET = 1'h1;
  localparam logic BUSY_FREE = 1'h0;
  localparam logic RELEASE_ACTIVE = 1'h1;
  localparam logic LINE_HIGH = 1'h1;
endpackage

// [verilog/ibt_sync.sv]
// Two flip-flop synchroniser for one asynchronous line
`timescale 1ns/10ps
`default_nettype none
module ibt_sync #(
  parameter logic INIT = 1'h1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
    if (rst) begin
      next_meta = INIT;
      next_dout = INIT;
    end
  end

  always_ff @(posedge clk) begin
    meta <= next_meta;
    dout <= next_dout;
  end
endmodule // ibt_sync
`default_nettype wire

// [verilog/ibt_tracker.sv]
// I2C bus busy tracker: START/STOP detection driving the busy flag
// Function
// - START detected sets busy flag to one
// - STOP detected clears busy flag to zero
// - No START/STOP detection while release low
// - Busy flag frozen when entering peripheral reset
// - Frozen flag updates only after release, event
// - Busy flag is zero after power-up
`timescale 1ns/10ps
`default_nettype none
module ibt_tracker (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic module_reset_release,
  output logic bus_busy_flag,
  output logic start_seen,
  output logic stop_seen
);
  logic scl_s;
  logic sda_s;
  logic rel_s;
  logic sda_d;
  logic next_sda_d;
  logic next_busy;
  logic next_start;
  logic next_stop;
  logic fall;
  logic rise;

  // Release bit is treated as asynchronous since software may sit elsewhere
  ibt_sync #(.INIT(ibt_pkg::LINE_HIGH)) u_scl (
    .clk(clk), .rst(rst), .din(scl_in), .dout(scl_s));
  ibt_sync #(.INIT(ibt_pkg::LINE_HIGH)) u_sda (
    .clk(clk), .rst(rst), .din(sda_in), .dout(sda_s));
  ibt_sync #(.INIT(~ibt_pkg::RELEASE_ACTIVE)) u_rel (
    .clk(clk), .rst(rst), .din(module_reset_release), .dout(rel_s));

  always_comb begin
    fall = (sda_d == ibt_pkg::LINE_HIGH) && (sda_s != ibt_pkg::LINE_HIGH);
    rise = (sda_d != ibt_pkg::LINE_HIGH) && (sda_s == ibt_pkg::LINE_HIGH);
    next_sda_d = sda_s;
    next_busy = bus_busy_flag;
    next_start = 1'h0;
    next_stop = 1'h0;
    if (rst) begin
      next_sda_d = ibt_pkg::LINE_HIGH;
      next_busy = ibt_pkg::BUSY_RESET;
    end else if (rel_s == ibt_pkg::RELEASE_ACTIVE) begin
      // Edge tracking keeps running in reset so no stale edge fires later
      if (scl_s == ibt_pkg::LINE_HIGH && fall) begin
        next_start = 1'h1;
        next_busy = ibt_pkg::BUSY_SET;
      end else if (scl_s == ibt_pkg::LINE_HIGH && rise) begin
        next_stop = 1'h1;
        next_busy = ibt_pkg::BUSY_FREE;
      end
    end
  end

  always_ff @(posedge clk) begin
    sda_d <= next_sda_d;
    bus_busy_flag <= next_busy;
    start_seen <= next_start;
    stop_seen <= next_stop;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence start_cond_s;
    rel_s && scl_s && fall;
  endsequence
  sequence stop_cond_s;
    rel_s && scl_s && rise;
  endsequence

  start_sets_a: assert property (start_cond_s |=> bus_busy_flag)
    else $error("busy flag not set after START");
  stop_clears_a: assert property (stop_cond_s |=> !bus_busy_flag)
    else $error("busy flag not cleared after STOP");
  no_detect_a: assert property (!rel_s |=> !start_seen && !stop_seen)
    else $error("condition detected while held in reset");
  frozen_flag_a: assert property (!rel_s |=> $stable(bus_busy_flag))
    else $error("busy flag moved while held in reset");
  change_cause_a: assert property ($changed(bus_busy_flag) |->
    $past(rel_s) && (start_seen || stop_seen))
    else $error("busy flag changed without a detected event");
  power_up_a: assert property (@(posedge clk)
    $fell(rst) |-> !bus_busy_flag)
    else $error("busy flag not zero after reset");
  start_edge_a: assert property (start_seen |->
    $past(scl_s) && $past(sda_d) && !$past(sda_s))
    else $error("START pulse without SDA fall under SCL high");
  stop_edge_a: assert property (stop_seen |->
    $past(scl_s) && !$past(sda_d) && $past(sda_s))
    else $error("STOP pulse without SDA rise under SCL high");

  // Check-only state below; nothing in the datapath reads it
  logic rel_seen;
  logic next_rel_seen;
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  logic settled;

  // Synchroniser history is only trusted once it has flushed past reset
  assign settled = (settle_cnt == 2'(ibt_pkg::SYNC_STAGES));

  always_comb begin
    next_rel_seen = rel_seen;
    next_settle_cnt = settle_cnt;
    if (rst) begin
      next_rel_seen = 1'h0;
      next_settle_cnt = 2'h0;
    end else begin
      if (rel_s == ibt_pkg::RELEASE_ACTIVE) begin
        next_rel_seen = 1'h1;
      end
      // Saturates, so a long run never wraps back to unsettled
      if (!settled) begin
        next_settle_cnt = settle_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    rel_seen <= next_rel_seen;
    settle_cnt <= next_settle_cnt;
  end

  // Pin-level view of a condition, before the synchronisers
  sequence pin_start_s;
    scl_in && module_reset_release && $fell(sda_in);
  endsequence

  sequence pin_stop_s;
    scl_in && module_reset_release && $rose(sda_in);
  endsequence

  sequence pin_held_s;
    scl_in && !module_reset_release && $changed(sda_in);
  endsequence

  sequence released_quiet_s;
    rel_s && !(scl_s && (fall || rise));
  endsequence

  sequence pulses_clear_s;
    !start_seen && !stop_seen;
  endsequence

  // End to end: pin edge to pulse is two sync stages plus one register
  pin_start_a: assert property (
    pin_start_s |-> ##3 start_seen)
    else $error("START on the pins not reported three cycles later");
  pin_stop_a: assert property (
    pin_stop_s |-> ##3 stop_seen)
    else $error("STOP on the pins not reported three cycles later");
  pin_held_a: assert property (
    pin_held_s |-> ##3 pulses_clear_s)
    else $error("condition reported while release was low");

  // Flag moves only with a detected condition or with rst
  quiet_hold_a: assert property (
    released_quiet_s |=> $stable(bus_busy_flag))
    else $error("busy flag moved with no detected condition");
  idle_power_a: assert property (
    !rel_seen |-> !bus_busy_flag)
    else $error("busy flag not zero before the first release");
  reset_clear_a: assert property (@(posedge clk) disable iff (1'h0)
    rst |=> pulses_clear_s ##0 !bus_busy_flag)
    else $error("outputs not cleared by reset");

  // Pulse and flag agree with each other
  pulse_excl_a: assert property (
    !(start_seen && stop_seen))
    else $error("START and STOP reported together");
  start_flag_a: assert property (
    start_seen |-> bus_busy_flag)
    else $error("START pulse with busy flag low");
  stop_flag_a: assert property (
    stop_seen |-> !bus_busy_flag)
    else $error("STOP pulse with busy flag high");
  flag_rise_a: assert property (
    $rose(bus_busy_flag) |-> start_seen)
    else $error("busy flag rose without a START pulse");
  flag_fall_a: assert property (
    $fell(bus_busy_flag) |-> stop_seen)
    else $error("busy flag fell without a STOP pulse");
  start_once_a: assert property (
    start_seen |=> !start_seen)
    else $error("START pulse longer than one cycle");
  stop_once_a: assert property (
    stop_seen |=> !stop_seen)
    else $error("STOP pulse longer than one cycle");

  // Each synchroniser lags its pin by exactly two cycles
  sync_scl_a: assert property (
    settled |-> scl_s == $past(scl_in, 2))
    else $error("SCL synchroniser does not lag the pin by two cycles");
  sync_sda_a: assert property (
    settled |-> sda_s == $past(sda_in, 2))
    else $error("SDA synchroniser does not lag the pin by two cycles");
  sync_rel_a: assert property (
    settled |-> rel_s == $past(module_reset_release, 2))
    else $error("release synchroniser does not lag by two cycles");
endmodule // ibt_tracker
`default_nettype wire

// [testbench/ibt_bus_model.sv]
// I2C master model making START and STOP on idle-high lines
`timescale 1ns/10ps
`default_nettype none
module ibt_bus_model (
  output var logic scl = 1'h1,
  output var logic sda = 1'h1
);
  task automatic cond(input logic stp);
    #5 scl = 1'h0;
    #100 sda = ~stp;
    #100 scl = 1'h1;
    #100 sda = stp;
    #100;
  endtask
endmodule // ibt_bus_model
`default_nettype wire

// [testbench/ibt_tracker_tb_top.sv]
// Bench for the I2C bus busy tracker
`timescale 1ns/10ps
`default_nettype none
module ibt_tracker_tb_top;
  logic clk, rst, rel, scl, sda, busy, st, sp;
  logic [1:0] q[$];
  logic [1:0] note;
  int err_total, cmp_count;
  ibt_bus_model u_bus (.scl(scl), .sda(sda));
  ibt_tracker u_dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .module_reset_release(rel), .bus_busy_flag(busy), .start_seen(st),
    .stop_seen(sp));
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value bus_busy_flag exp %b got %b", e, g);
    end
  endtask
  task automatic chk_kind(input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value stop_seen exp %b got %b", e, g);
    end
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Note the flag a condition should leave, unless it must be ignored
  // Note holds the expected stop pulse above the expected flag
  task automatic ev(input logic stp, input logic keep);
    if (keep) q.push_back({stp, ~stp});
    u_bus.cond(stp);
    repeat (4) @(posedge clk);
    cmp_count++;
    if (q.size() != 0) begin
      err_total++;
      $display("wrong value pulse_count exp %0d got %0d", 0, q.size());
      q.delete();
    end
  endtask
  always @(posedge clk)
    if (st === 1'h1 || sp === 1'h1) begin
      if (q.size() == 0) begin
        err_total++;
        $display("wrong value pulse_count exp %0d got %0d", 0, 1);
      end else begin
        note = q.pop_front();
        chk(note[0], busy);
        chk_kind(note[1], sp);
      end
    end
  initial begin
    rst = 1'h1;
    rel = 1'h0;
    void'($urandom(32'h2c1aa025));
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk(1'h0, busy);
    ev(1'h0, 1'h0);
    chk(1'h0, busy);
    $display("test power-up done");
    rel <= 1'h1;
    repeat (4) @(posedge clk);
    chk(1'h0, busy);
    ev(1'h0, 1'h1);
    ev(1'h1, 1'h1);
    ev(1'h0, 1'h1);
    rel <= 1'h0;
    repeat (4) @(posedge clk);
    ev(1'h1, 1'h0);
    chk(1'h1, busy);
    rel <= 1'h1;
    repeat (4 + $urandom % 8) @(posedge clk);
    chk(1'h1, busy);
    ev(1'h1, 1'h1);
    $display("test freeze done");
    repeat (6) ev(1'($urandom % 2), 1'h1);
    $display("test random done");
    stop_test();
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule // ibt_tracker_tb_top
`default_nettype wire
